// [clock_source_prescale_ctrl.sv]
// clock_source_prescale_ctrl: clock source, prescaler and pll control regs
// assumes one 40 mhz clock, an avalon-mm master with waitrequest, gpio
// pins from outside the clock domain and fuse words stable at reset
//
// Operation
// RULE_01: pin enable bits gate gpio pins 10-4
// RULE_02: audio3 master clock source select, bits 31:30
// RULE_03: audio2 master clock source select, bits 29:28
// RULE_04: audio1 master clock source select, bits 27:26
// RULE_05: pll derived audio clock divided inside interface
// RULE_06: serial port master clock source, bits 25:24
// RULE_07: serial prescaler divides by field plus one
// RULE_08: main prescaler divides source by field plus one
// RULE_09: peripheral bus divides system bus by code
// RULE_10: system bus scale divides processor clock
// RULE_11: timer trigger pin select, constants 1e/1f
// RULE_12: alternate reference pin select, constants 1e/1f
// RULE_13: software sets second stage filter range
// RULE_14: software sets first stage filter range
// RULE_15: bit 7 bypasses second pll stage
// RULE_16: bit 6 bypasses first pll stage
// RULE_17: bits 5/4 hold pll stages in reset
// RULE_18: custom parts load start values from fuses
// RULE_19: fixed reset values of the three registers
// RULE_20: main source select with glitch free switch
//
// The Avalon-MM register port was chosen for this implementation.
`default_nettype none
module clock_source_prescale_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // fuse start-up contents
  input wire logic fuse_custom,
  input wire logic [31:0] fuse_gpio_word,
  input wire logic [31:0] fuse_ctrl1_word,
  input wire logic [31:0] fuse_ctrl2_word,
  // gpio pins, asynchronous
  input wire logic [29:0] gpio_pins,
  // outputs to pads, clock tree and pll
  output logic [6:0] pin_enable,
  output clock_source_prescale_pkg::clock_sources_t clock_sources,
  output clock_source_prescale_pkg::pll_controls_t pll_controls,
  output logic processor_clock_en,
  output logic system_bus_clock_en,
  output logic peripheral_bus_clock_en,
  output logic serial_port_clock_en,
  output logic alternate_reference_clock,
  output logic timer_trigger
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // pick a gpio pin by select code; 1e and 1f are fixed levels
  function automatic logic pick_pin(input logic [4:0] code,
                                    input logic [29:0] pins);
    logic res;
    res = 1'b0;
    if (code == clock_source_prescale_pkg::PIN_CONST_ONE) begin
      res = 1'b1;
    end else if (code != clock_source_prescale_pkg::PIN_CONST_ZERO) begin
      res = pins[code];
    end
    return res;
  endfunction : pick_pin

  // merge a bus write by byte lanes, reserved bits forced low
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [3:0] be,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0] gpio_sel;       // pin enable select register
    logic [31:0] ctrl1;          // source and prescale register
    logic [31:0] ctrl2;          // pll and reference select register
    logic boot_done;             // fuse load slot has passed
    logic wait_n;                // low for the single answer cycle
    logic [31:0] rdata;          // read answer
    logic [29:0] pin_meta;       // first synchroniser stage
    logic [29:0] pin_sync;       // second synchroniser stage
    logic [7:0] main_cnt;        // main prescaler count
    logic [1:0] sys_cnt;         // system bus scale count
    logic [4:0] per_cnt;         // peripheral bus count
    logic [5:0] ser_cnt;         // serial prescaler count
    logic proc_en;               // processor clock enable
    logic sys_en;                // system bus enable
    logic per_en;                // peripheral bus enable
    logic ser_en;                // serial port enable
    logic [2:0] main_src;        // applied main source
    logic alt_ref;               // selected alternate reference
    logic tmr_ref;               // selected timer trigger
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // field views of the registers
  logic [7:0] main_div;
  logic [1:0] sys_scale;
  logic [2:0] per_code;
  logic [5:0] ser_div;
  logic ser_ref;
  logic [4:0] tmr_pin;
  logic [4:0] alt_pin;
  logic [2:0] main_req;
  logic [1:0] sys_limit;
  logic [4:0] per_limit;
  logic access;

  assign main_div = st_ff.ctrl1[clock_source_prescale_pkg::MAIN_DIV_LO +: 8];
  assign sys_scale =
    st_ff.ctrl1[clock_source_prescale_pkg::SYSBUS_SCALE_LO +: 2];
  assign per_code = st_ff.ctrl1[clock_source_prescale_pkg::PERIPH_DIV_LO +: 3];
  assign ser_div = st_ff.ctrl1[clock_source_prescale_pkg::SERIAL_DIV_LO +: 6];
  assign ser_ref = st_ff.ctrl2[clock_source_prescale_pkg::SERIAL_REF_BIT];
  assign tmr_pin = st_ff.ctrl2[clock_source_prescale_pkg::TIMER_PIN_LO +: 5];
  assign alt_pin = st_ff.ctrl2[clock_source_prescale_pkg::ALT_PIN_LO +: 5];
  assign main_req = st_ff.ctrl2[clock_source_prescale_pkg::MAIN_SRC_LO +: 3];
  assign access = (read | write) & st_ff.wait_n & st_ff.boot_done;

  // RULE_10 system bus scale: 00 by 1, 01 by 2, 10 by 4, 11 treated as 1
  always_comb begin
    case (sys_scale)
      2'h1: sys_limit = 2'h1;
      2'h2: sys_limit = 2'h3;
      default: sys_limit = 2'h0;
    endcase
  end

  // RULE_09 peripheral division: by 2^code up to 32, reserved codes by 1
  always_comb begin
    case (per_code)
      3'h1: per_limit = 5'h01;
      3'h2: per_limit = 5'h03;
      3'h3: per_limit = 5'h07;
      3'h4: per_limit = 5'h0f;
      3'h5: per_limit = 5'h1f;
      default: per_limit = 5'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;
    // pins pass two flops before anything reads them
    nxt_st.pin_meta = gpio_pins;
    nxt_st.pin_sync = st_ff.pin_meta;

    // RULE_18 fuse contents replace reset values once after release
    if (!st_ff.boot_done) begin
      nxt_st.boot_done = 1'b1;
      if (fuse_custom) begin
        nxt_st.gpio_sel = fuse_gpio_word &
                          clock_source_prescale_pkg::GPIO_SEL_MASK;
        nxt_st.ctrl1 = fuse_ctrl1_word &
                       clock_source_prescale_pkg::CLK_CTRL1_MASK;
        nxt_st.ctrl2 = fuse_ctrl2_word &
                       clock_source_prescale_pkg::CLK_CTRL2_MASK;
      end
    end

    // bus: one wait cycle, then one answer cycle with waitrequest low
    nxt_st.wait_n = 1'b1;
    if (access) begin
      nxt_st.wait_n = 1'b0;
      case (address)
        clock_source_prescale_pkg::GPIO_SEL_ADDR:
          nxt_st.rdata = st_ff.gpio_sel;
        clock_source_prescale_pkg::CLK_CTRL1_ADDR: nxt_st.rdata = st_ff.ctrl1;
        clock_source_prescale_pkg::CLK_CTRL2_ADDR: nxt_st.rdata = st_ff.ctrl2;
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
    // write lands at the edge where waitrequest is seen low
    if (!st_ff.wait_n && write) begin
      case (address)
        clock_source_prescale_pkg::GPIO_SEL_ADDR: begin
          nxt_st.gpio_sel = merge(st_ff.gpio_sel, writedata, byteenable,
                                  clock_source_prescale_pkg::GPIO_SEL_MASK);
        end
        clock_source_prescale_pkg::CLK_CTRL1_ADDR: begin
          nxt_st.ctrl1 = merge(st_ff.ctrl1, writedata, byteenable,
                               clock_source_prescale_pkg::CLK_CTRL1_MASK);
        end
        clock_source_prescale_pkg::CLK_CTRL2_ADDR: begin
          nxt_st.ctrl2 = merge(st_ff.ctrl2, writedata, byteenable,
                               clock_source_prescale_pkg::CLK_CTRL2_MASK);
        end
        default: begin
          // unmapped write is dropped
        end
      endcase
    end

    // RULE_08 main prescaler: one enable every main_div+1 cycles
    nxt_st.proc_en = 1'b0;
    nxt_st.sys_en = 1'b0;
    nxt_st.per_en = 1'b0;
    if (st_ff.main_cnt >= main_div) begin
      nxt_st.main_cnt = 8'h00;
      nxt_st.proc_en = 1'b1;
      // RULE_20 source changes only at a processor clock boundary
      if (main_req <= clock_source_prescale_pkg::MAIN_SRC_MAX) begin
        nxt_st.main_src = main_req;
      end
      // RULE_10 system bus counts processor enables
      if (st_ff.sys_cnt >= sys_limit) begin
        nxt_st.sys_cnt = 2'h0;
        nxt_st.sys_en = 1'b1;
        // RULE_09 peripheral bus counts system bus enables
        if (st_ff.per_cnt >= per_limit) begin
          nxt_st.per_cnt = 5'h00;
          nxt_st.per_en = 1'b1;
        end else begin
          nxt_st.per_cnt = st_ff.per_cnt + 5'h01;
        end
      end else begin
        nxt_st.sys_cnt = st_ff.sys_cnt + 2'h1;
      end
    end else begin
      nxt_st.main_cnt = st_ff.main_cnt + 8'h01;
    end

    // RULE_07 serial prescaler, bypassed when the reference bit is set
    if (ser_ref || st_ff.ser_cnt >= ser_div) begin
      nxt_st.ser_cnt = 6'h00;
      nxt_st.ser_en = 1'b1;
    end else begin
      nxt_st.ser_cnt = st_ff.ser_cnt + 6'h01;
      nxt_st.ser_en = 1'b0;
    end

    // RULE_11 timer trigger from the chosen pin or a constant
    nxt_st.tmr_ref = pick_pin(tmr_pin, st_ff.pin_sync);
    // RULE_12 alternate reference from the chosen pin or a constant
    nxt_st.alt_ref = pick_pin(alt_pin, st_ff.pin_sync);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // RULE_19 fixed reset values; fuses are applied after release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.gpio_sel <= clock_source_prescale_pkg::GPIO_SEL_RST;
      st_ff.ctrl1 <= clock_source_prescale_pkg::CLK_CTRL1_RST;
      st_ff.ctrl2 <= clock_source_prescale_pkg::CLK_CTRL2_RST;
      st_ff.wait_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.wait_n;
  // RULE_01 pin enables; pad pull settings live elsewhere, always active
  assign pin_enable = st_ff.gpio_sel[clock_source_prescale_pkg::PIN_EN_HI:
                                     clock_source_prescale_pkg::PIN_EN_LO];
  // RULE_02 audio3 source code, 11 passed on as reserved
  assign clock_sources.audio3 =
    st_ff.ctrl1[clock_source_prescale_pkg::AUDIO3_SRC_LO +: 2];
  // RULE_03 audio2 source code
  assign clock_sources.audio2 =
    st_ff.ctrl1[clock_source_prescale_pkg::AUDIO2_SRC_LO +: 2];
  // RULE_04 audio1 source code; RULE_05 pll option divided downstream
  assign clock_sources.audio1 =
    st_ff.ctrl1[clock_source_prescale_pkg::AUDIO1_SRC_LO +: 2];
  // RULE_06 serial port source code
  assign clock_sources.serial =
    st_ff.ctrl1[clock_source_prescale_pkg::SERIAL_SRC_LO +: 2];
  assign clock_sources.main = st_ff.main_src;
  // RULE_13 range passed through as software set it
  assign pll_controls.stage2_range =
    st_ff.ctrl2[clock_source_prescale_pkg::STAGE2_RANGE_LO +: 3];
  // RULE_14 range passed through as software set it
  assign pll_controls.stage1_range =
    st_ff.ctrl2[clock_source_prescale_pkg::STAGE1_RANGE_LO +: 3];
  // RULE_15 second stage bypass
  assign pll_controls.stage2_bypass =
    st_ff.ctrl2[clock_source_prescale_pkg::STAGE2_BYPASS_BIT];
  // RULE_16 first stage bypass
  assign pll_controls.stage1_bypass =
    st_ff.ctrl2[clock_source_prescale_pkg::STAGE1_BYPASS_BIT];
  // RULE_17 stage resets held while bits are one
  assign pll_controls.stage2_reset =
    st_ff.ctrl2[clock_source_prescale_pkg::STAGE2_RESET_BIT];
  assign pll_controls.stage1_reset =
    st_ff.ctrl2[clock_source_prescale_pkg::STAGE1_RESET_BIT];
  assign processor_clock_en = st_ff.proc_en;
  assign system_bus_clock_en = st_ff.sys_en;
  assign peripheral_bus_clock_en = st_ff.per_en;
  assign serial_port_clock_en = st_ff.ser_en;
  assign alternate_reference_clock = st_ff.alt_ref;
  assign timer_trigger = st_ff.tmr_ref;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence ctrl1_write_s;
    !waitrequest && write && byteenable == 4'hf
      && address == clock_source_prescale_pkg::CLK_CTRL1_ADDR;
  endsequence

  answer_one_cycle_a: assert property ( // bus handshake, no RULE entry
    !waitrequest |=> waitrequest) else $error("answer longer than a cycle");
  ctrl1_write_lands_a: assert property ( // RULE_08
    ctrl1_write_s |=> st_ff.ctrl1 ==
      ($past(writedata) & clock_source_prescale_pkg::CLK_CTRL1_MASK))
    else $error("ctrl1 write lost");
  reset_values_a: assert property ( // RULE_19
    $fell(sys_rst) |-> st_ff.ctrl2 == clock_source_prescale_pkg::CLK_CTRL2_RST
      && st_ff.ctrl1 == clock_source_prescale_pkg::CLK_CTRL1_RST)
    else $error("reset value wrong");
  fuse_load_a: assert property ( // RULE_18
    $fell(sys_rst) && fuse_custom |=> st_ff.gpio_sel ==
      ($past(fuse_gpio_word) & clock_source_prescale_pkg::GPIO_SEL_MASK))
    else $error("fuse word not loaded");
  timer_const_a: assert property ( // RULE_11
    (tmr_pin == clock_source_prescale_pkg::PIN_CONST_ONE) [*2] |=>
      timer_trigger) else $error("timer constant one missing");
  main_div_two_a: assert property ( // RULE_08
    processor_clock_en && main_div == 8'h01 ##1 $stable(main_div) |->
      !processor_clock_en ##1 processor_clock_en)
    else $error("divide by two wrong");
  serial_bypass_a: assert property ( // RULE_07
    ser_ref [*2] |-> serial_port_clock_en) else $error("serial bypass off");
  main_switch_edge_a: assert property ( // RULE_20
    $changed(clock_sources.main) |-> processor_clock_en)
    else $error("main source switched mid period");
  pin_enable_follow_a: assert property ( // RULE_01
    !waitrequest && write && byteenable == 4'hf &&
      address == clock_source_prescale_pkg::GPIO_SEL_ADDR |=>
      pin_enable == $past(writedata[clock_source_prescale_pkg::PIN_EN_HI:
                                    clock_source_prescale_pkg::PIN_EN_LO]))
    else $error("pin enable mismatch");
  bypass_follow_a: assert property ( // RULE_15
    !waitrequest && write && byteenable == 4'hf &&
      address == clock_source_prescale_pkg::CLK_CTRL2_ADDR |=>
      pll_controls.stage2_bypass ==
        $past(writedata[clock_source_prescale_pkg::STAGE2_BYPASS_BIT]))
    else $error("bypass mismatch");

endmodule : clock_source_prescale_ctrl
`default_nettype wire

// [clock_source_prescale_pkg.sv]
// clock_source_prescale_pkg: register map, field layout, reset values
// assumes a 32-bit avalon-mm slave port and a 30-pin gpio bank
`default_nettype none
package clock_source_prescale_pkg;
  // register byte addresses
  localparam logic [31:0] GPIO_SEL_ADDR = 32'hf000000c;
  localparam logic [31:0] CLK_CTRL1_ADDR = 32'hf0000010;
  localparam logic [31:0] CLK_CTRL2_ADDR = 32'hf0000014;
  // reset values without fuse override
  localparam logic [31:0] GPIO_SEL_RST = 32'h00000000;
  localparam logic [31:0] CLK_CTRL1_RST = 32'h00000011;
  localparam logic [31:0] CLK_CTRL2_RST = 32'h03de0000;
  // writable bits; reserved bits stay zero
  localparam logic [31:0] GPIO_SEL_MASK = 32'h10ce7ff0;
  localparam logic [31:0] CLK_CTRL1_MASK = 32'hff3fff73;
  localparam logic [31:0] CLK_CTRL2_MASK = 32'h53ff77f7;
  // gpio select register fields
  localparam int PIN_EN_LO = 4;
  localparam int PIN_EN_HI = 10;
  // clock control 1 fields
  localparam int AUDIO3_SRC_LO = 30;
  localparam int AUDIO2_SRC_LO = 28;
  localparam int AUDIO1_SRC_LO = 26;
  localparam int SERIAL_SRC_LO = 24;
  localparam int SERIAL_DIV_LO = 16;
  localparam int MAIN_DIV_LO = 8;
  localparam int PERIPH_DIV_LO = 4;
  localparam int SYSBUS_SCALE_LO = 0;
  // clock control 2 fields
  localparam int SERIAL_REF_BIT = 28;
  localparam int TIMER_PIN_LO = 21;
  localparam int ALT_PIN_LO = 16;
  localparam int STAGE2_RANGE_LO = 12;
  localparam int STAGE1_RANGE_LO = 8;
  localparam int STAGE2_BYPASS_BIT = 7;
  localparam int STAGE1_BYPASS_BIT = 6;
  localparam int STAGE2_RESET_BIT = 5;
  localparam int STAGE1_RESET_BIT = 4;
  localparam int MAIN_SRC_LO = 0;
  // pin select codes
  localparam int PIN_COUNT = 30;
  localparam logic [4:0] PIN_CONST_ZERO = 5'h1e;
  localparam logic [4:0] PIN_CONST_ONE = 5'h1f;
  // clock source codes
  localparam logic [1:0] SRC_INPUT_REF = 2'h0;
  localparam logic [1:0] SRC_PLL = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;
  localparam logic [2:0] MAIN_SRC_MAX = 3'h2;

  // clock source selections handed to the clock tree
  typedef struct packed {
    logic [1:0] audio3;
    logic [1:0] audio2;
    logic [1:0] audio1;
    logic [1:0] serial;
    logic [2:0] main;
  } clock_sources_t;

  // controls of the two pll stages
  typedef struct packed {
    logic [2:0] stage2_range;
    logic [2:0] stage1_range;
    logic stage2_bypass;
    logic stage1_bypass;
    logic stage2_reset;
    logic stage1_reset;
  } pll_controls_t;
endpackage : clock_source_prescale_pkg
`default_nettype wire

// [testbench.sv]
// testbench: self-checking bench for clock_source_prescale_ctrl
// assumes one 40 mhz clock and the register map of the design package
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk; // 25 ns period
  logic sys_rst;
  logic [31:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic fuse_custom;
  logic [31:0] fuse_word; // ctrl1 sees it inverted, ctrl2 halves swapped
  logic [29:0] gpio_pins;
  logic [6:0] pin_enable;
  clock_source_prescale_pkg::clock_sources_t clock_sources;
  clock_source_prescale_pkg::pll_controls_t pll_controls;
  logic [3:0] ens; // serial, peripheral, system, processor enables
  logic alt_clk;
  logic timer_trigger;
  int err_total;
  int n_checks;
  logic [31:0] rd;
  int n;

  clock_source_prescale_ctrl u_dut (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .fuse_custom(fuse_custom), .fuse_gpio_word(fuse_word),
    .fuse_ctrl1_word(~fuse_word),
    .fuse_ctrl2_word({fuse_word[15:0], fuse_word[31:16]}),
    .gpio_pins(gpio_pins), .pin_enable(pin_enable),
    .clock_sources(clock_sources), .pll_controls(pll_controls),
    .processor_clock_en(ens[0]), .system_bus_clock_en(ens[1]),
    .peripheral_bus_clock_en(ens[2]), .serial_port_clock_en(ens[3]),
    .alternate_reference_clock(alt_clk), .timer_trigger(timer_trigger)
  );

  //////////////////////////////////////////////////////////////////////////
  // clock source
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one compare; unknowns match only identical expected unknowns
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // avalon read: one idle edge first so strobes never toggle twice at once
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    int t;
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 100);
    d = readdata;
    read <= 1'b0;
    if (t >= 100) err_total++;
  endtask : bus_rd

  // avalon write, held until waitrequest is sampled low
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 100);
    write <= 1'b0;
    if (t >= 100) err_total++;
  endtask : bus_wr

  // cycles between two enable pulses; second gap, dividers load live
  task automatic measure(input int k, output int p);
    int t;
    for (int r = 0; r < 2; r++) begin
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (ens[k] !== 1'b1 && t < 3000);
    end
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (ens[k] !== 1'b1 && p < 3000);
  endtask : measure

  //////////////////////////////////////////////////////////////////////////
  // reset contents and the unmapped address
  task automatic t_reset_values();
    bus_rd(clock_source_prescale_pkg::GPIO_SEL_ADDR, rd);
    `CHK(rd, 32'h00000000);
    bus_rd(clock_source_prescale_pkg::CLK_CTRL1_ADDR, rd);
    `CHK(rd, 32'h00000011);
    bus_rd(clock_source_prescale_pkg::CLK_CTRL2_ADDR, rd);
    `CHK(rd, 32'h03de0000);
    `CHK(clock_sources, 11'h000);
    `CHK(pll_controls, 10'h000);
    `CHK({timer_trigger, alt_clk}, 2'b00);
    bus_wr(32'hf0000018, 32'hffffffff);
    bus_rd(32'hf0000018, rd);
    `CHK(rd, 32'h00000000);
    $display("%0t test reset_values done", $time);
  endtask : t_reset_values

  // pin enable bits reach the pads
  task automatic t_pin_enable();
    bus_wr(clock_source_prescale_pkg::GPIO_SEL_ADDR, 32'hffffffff);
    bus_rd(clock_source_prescale_pkg::GPIO_SEL_ADDR, rd);
    `CHK(rd, clock_source_prescale_pkg::GPIO_SEL_MASK);
    `CHK(pin_enable, 7'h7f);
    bus_wr(clock_source_prescale_pkg::GPIO_SEL_ADDR, 32'h00000550);
    repeat (2) @(posedge clk);
    `CHK(pin_enable, 7'h55);
    $display("%0t test pin_enable done", $time);
  endtask : t_pin_enable

  // source selects and a set of divider codes for each prescaler
  task automatic t_dividers();
    int sc[3] = '{1, 2, 4};
    int pd[5] = '{1, 2, 8, 16, 32};
    int pc[5] = '{0, 1, 3, 4, 5};
    bus_wr(clock_source_prescale_pkg::CLK_CTRL1_ADDR, 32'h91050332);
    bus_rd(clock_source_prescale_pkg::CLK_CTRL1_ADDR, rd);
    `CHK(clock_sources.audio3, 2'h2);
    `CHK(clock_sources.audio2, 2'h1);
    `CHK(clock_sources.audio1, 2'h0);
    `CHK(clock_sources.serial, 2'h1);
    measure(0, n);
    `CHK(n, 4);
    measure(3, n);
    `CHK(n, 6);
    bus_wr(clock_source_prescale_pkg::CLK_CTRL1_ADDR, 32'hc03fff00);
    measure(0, n);
    `CHK(n, 256);
    measure(3, n);
    `CHK(n, 64);
    // main divides by two in this loop, so every period doubles
    for (int i = 0; i < 5; i++) begin
      bus_wr(clock_source_prescale_pkg::CLK_CTRL1_ADDR,
             32'h00000100 | 32'(pc[i] << 4) | 32'(i % 3));
      measure(0, n);
      `CHK(n, 2);
      measure(1, n);
      `CHK(n, 2 * sc[i % 3]);
      measure(2, n);
      `CHK(n, 2 * sc[i % 3] * pd[i]);
    end
    $display("%0t test dividers done", $time);
  endtask : t_dividers

  // pll controls, pin selects, main source and serial bypass
  task automatic t_pll_pins();
    bus_wr(clock_source_prescale_pkg::CLK_CTRL2_ADDR, 32'h03fe65a1);
    bus_rd(clock_source_prescale_pkg::CLK_CTRL2_ADDR, rd);
    `CHK(rd, 32'h03fe65a1);
    repeat (4) @(posedge clk);
    `CHK(pll_controls, {3'h6, 3'h5, 4'ha});
    `CHK({timer_trigger, alt_clk}, 2'b10);
    `CHK(clock_sources.main, 3'h1);
    bus_wr(clock_source_prescale_pkg::CLK_CTRL2_ADDR, 32'h10671252);
    gpio_pins <= 30'h00000008;
    repeat (4) @(posedge clk);
    `CHK(pll_controls, {3'h1, 3'h2, 4'h5});
    `CHK(clock_sources.main, 3'h2);
    `CHK({timer_trigger, alt_clk}, 2'b10);
    measure(3, n);
    `CHK(n, 1);
    gpio_pins <= 30'h00000080;
    repeat (4) @(posedge clk);
    `CHK({timer_trigger, alt_clk}, 2'b01);
    bus_wr(clock_source_prescale_pkg::CLK_CTRL2_ADDR, 32'h13df1255);
    repeat (4) @(posedge clk);
    `CHK({timer_trigger, alt_clk}, 2'b01);
    `CHK(clock_sources.main, 3'h2);
    $display("%0t test pll_pins done", $time);
  endtask : t_pll_pins

  // start-up contents from the fuse words after a second reset
  task automatic t_fuse();
    logic [31:0] exp1; // ctrl1 fuse word after masking
    logic [31:0] exp2; // ctrl2 fuse word after masking
    exp1 = ~fuse_word & clock_source_prescale_pkg::CLK_CTRL1_MASK;
    exp2 = {fuse_word[15:0], fuse_word[31:16]} &
           clock_source_prescale_pkg::CLK_CTRL2_MASK;
    fuse_custom <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    bus_rd(clock_source_prescale_pkg::GPIO_SEL_ADDR, rd);
    `CHK(rd, fuse_word & clock_source_prescale_pkg::GPIO_SEL_MASK);
    bus_rd(clock_source_prescale_pkg::CLK_CTRL1_ADDR, rd);
    `CHK(rd, exp1);
    bus_rd(clock_source_prescale_pkg::CLK_CTRL2_ADDR, rd);
    `CHK(rd, exp2);
    $display("%0t test fuse done", $time);
  endtask : t_fuse

  // verdict and end of run
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    address = 32'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hf;
    writedata = 32'h0;
    fuse_custom = 1'b0;
    fuse_word = 32'h0f0fa5c3;
    gpio_pins = 30'h0;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_pin_enable();
    t_dividers();
    t_pll_pins();
    t_fuse();
    stop_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
